// ### hdl/analog_frontend_config_regs.sv
// configuration register bank for the analog front end and output lanes
// ==========================================================
`timescale 1ns/1ps
`default_nettype none

module analog_frontend_config_regs (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic linkIsSingle,
   input wire logic calEnable,
   output logic [15:0] inputAFullscaleCode,
   output logic [15:0] inputBFullscaleCode,
   output logic inputALowRange,
   output logic inputBLowRange,
   output logic referenceSourceBypass,
   output logic stampReceiverOn,
   output logic stampLowswingMode,
   output logic [47:0] lanePreemphLevel,
   output logic [15:0] lanePreemphExtra,
   output logic convASampleB,
   output logic convBSampleB,
   output logic routingPending
);

   // ==========================================================
   // address decode
   function automatic logic regHit(input logic [11:0] addr, input logic [11:0] offset);
      regHit = (addr == offset);
   endfunction

   // below the recommended minimum code performance degrades
   function automatic logic belowRecommended(input logic [15:0] code);
      belowRecommended = (code < afe_cfg_pkg::FS_CODE_MIN_RECOMMENDED);
   endfunction

   // ==========================================================
   // register state
   logic [15:0] fsA_q, fsA_d;
   logic [15:0] fsB_q, fsB_d;
   logic [7:0] refBypass_q, refBypass_d;
   logic [7:0] stampCtrl_q, stampCtrl_d;
   logic [7:0] preemph_q, preemph_d;
   logic [7:0] routing_q, routing_d;
   logic [15:0] rdData_q, rdData_d;
   logic [1:0] lowRange_q, lowRange_d;
   logic calHeldSig;
   logic [7:0] appliedRouting;

   // write decode and next values
   always_comb begin
      fsA_d = fsA_q;
      fsB_d = fsB_q;
      refBypass_d = refBypass_q;
      stampCtrl_d = stampCtrl_q;
      preemph_d = preemph_q;
      routing_d = routing_q;
      if (regWrite) begin
         // fullscale codes stored at full width, other registers keep only the low byte, reserved bits kept as written
         if (regHit(regAddr, afe_cfg_pkg::OFF_INPUT_A_FULLSCALE)) begin
            fsA_d = regWrData;
         end
         if (regHit(regAddr, afe_cfg_pkg::OFF_INPUT_B_FULLSCALE)) begin
            fsB_d = regWrData;
         end
         if (regHit(regAddr, afe_cfg_pkg::OFF_REFERENCE_BYPASS)) begin
            refBypass_d = regWrData[7:0];
         end
         if (regHit(regAddr, afe_cfg_pkg::OFF_STAMP_INPUT_CONTROL)) begin
            stampCtrl_d = regWrData[7:0];
         end
         if (regHit(regAddr, afe_cfg_pkg::OFF_LANE_PREEMPHASIS)) begin
            preemph_d = regWrData[7:0];
         end
         if (regHit(regAddr, afe_cfg_pkg::OFF_INPUT_ROUTING)) begin
            routing_d = regWrData[7:0];
         end
      end
   end

   // register write state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fsA_q <= afe_cfg_pkg::RST_FULLSCALE;
         fsB_q <= afe_cfg_pkg::RST_FULLSCALE;
         refBypass_q <= afe_cfg_pkg::RST_REFERENCE_BYPASS;
         stampCtrl_q <= afe_cfg_pkg::RST_STAMP_INPUT_CONTROL;
         preemph_q <= afe_cfg_pkg::RST_LANE_PREEMPHASIS;
         routing_q <= afe_cfg_pkg::RST_INPUT_ROUTING;
      end else begin
         fsA_q <= fsA_d;
         fsB_q <= fsB_d;
         refBypass_q <= refBypass_d;
         stampCtrl_q <= stampCtrl_d;
         preemph_q <= preemph_d;
         routing_q <= routing_d;
      end
   end

   // ==========================================================
   // read path: data one cycle after the strobe, zero otherwise
   always_comb begin
      rdData_d = 16'h0000;
      if (regRead) begin
         // pure mux, no register changes on a read
         if (regHit(regAddr, afe_cfg_pkg::OFF_INPUT_A_FULLSCALE)) begin
            rdData_d = fsA_q;
         end else if (regHit(regAddr, afe_cfg_pkg::OFF_INPUT_B_FULLSCALE)) begin
            rdData_d = fsB_q;
         end else if (regHit(regAddr, afe_cfg_pkg::OFF_REFERENCE_BYPASS)) begin
            rdData_d = {8'h00, refBypass_q};
         end else if (regHit(regAddr, afe_cfg_pkg::OFF_STAMP_INPUT_CONTROL)) begin
            rdData_d = {8'h00, stampCtrl_q};
         end else if (regHit(regAddr, afe_cfg_pkg::OFF_LANE_PREEMPHASIS)) begin
            rdData_d = {8'h00, preemph_q};
         end else if (regHit(regAddr, afe_cfg_pkg::OFF_INPUT_ROUTING)) begin
            rdData_d = {8'h00, routing_q};
         end else if (regHit(regAddr, afe_cfg_pkg::OFF_ROUTING_STATUS)) begin
            // applied routing in the high byte, gate status low
            rdData_d = {appliedRouting, 6'h00, calHeldSig, routingPending};
         end
      end
   end

   // read data register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData_q <= 16'h0000;
      end else begin
         rdData_q <= rdData_d;
      end
   end

   assign regRdData = rdData_q;

   // ==========================================================
   // analog controls decoded from stored fields
   assign inputAFullscaleCode = fsA_q;
   assign inputBFullscaleCode = fsB_q;
   assign referenceSourceBypass = refBypass_q[afe_cfg_pkg::POS_REFERENCE_SOURCE_BYPASS];
   assign stampReceiverOn = stampCtrl_q[afe_cfg_pkg::POS_STAMP_RECEIVER_ON];
   assign stampLowswingMode = stampCtrl_q[afe_cfg_pkg::POS_STAMP_LOWSWING_MODE];

   // degraded-range warnings, registered
   always_comb begin
      lowRange_d = 2'h0;
      lowRange_d[0] = belowRecommended(fsA_d);
      lowRange_d[1] = belowRecommended(fsB_d);
   end

   // warning flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lowRange_q <= 2'h0;
      end else begin
         lowRange_q <= lowRange_d;
      end
   end

   assign inputALowRange = lowRange_q[0];
   assign inputBLowRange = lowRange_q[1];

   // ==========================================================
   // one common pre-emphasis setting fanned out to every lane
   genvar lane;
   generate
      for (lane = 0; lane < afe_cfg_pkg::LANE_COUNT; lane = lane + 1) begin : g_lane
         assign lanePreemphLevel[lane*3 +: 3] =
            preemph_q[afe_cfg_pkg::POS_LANE_PREEMPH_LEVEL +: 3];
         assign lanePreemphExtra[lane] =
            preemph_q[afe_cfg_pkg::POS_LANE_PREEMPH_EXTRA];
      end
   endgenerate

   // ==========================================================
   // input multiplexer steering, applied on calibration run
   input_routing_apply u_routing (
      .clk(clk),
      .rstn(rstn),
      .routingReg(routing_q),
      .linkIsSingle(linkIsSingle),
      .calEnable(calEnable),
      .convASampleB(convASampleB),
      .convBSampleB(convBSampleB),
      .routingPending(routingPending),
      .calHeld(calHeldSig),
      .appliedRouting(appliedRouting)
   );

endmodule

`default_nettype wire

// ### hdl/afe_cfg_pkg.sv
// constants for the analog front end configuration register bank
package afe_cfg_pkg;

   // ==========================================================
   // bus widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;

   // ==========================================================
   // register offsets, byte addresses as printed
   localparam logic [11:0] OFF_INPUT_A_FULLSCALE = 12'h030;
   localparam logic [11:0] OFF_INPUT_B_FULLSCALE = 12'h032;
   localparam logic [11:0] OFF_REFERENCE_BYPASS = 12'h038;
   localparam logic [11:0] OFF_STAMP_INPUT_CONTROL = 12'h03B;
   localparam logic [11:0] OFF_LANE_PREEMPHASIS = 12'h048;
   localparam logic [11:0] OFF_INPUT_ROUTING = 12'h060;
   localparam logic [11:0] OFF_ROUTING_STATUS = 12'h06F;

   // ==========================================================
   // reset values
   localparam logic [15:0] RST_FULLSCALE = 16'hA000;
   localparam logic [7:0] RST_REFERENCE_BYPASS = 8'h00;
   localparam logic [7:0] RST_STAMP_INPUT_CONTROL = 8'h00;
   localparam logic [7:0] RST_LANE_PREEMPHASIS = 8'h00;
   localparam logic [7:0] RST_INPUT_ROUTING = 8'h01;

   // ==========================================================
   // full-scale code landmarks
   localparam logic [15:0] FS_CODE_MIN_RECOMMENDED = 16'h2000; // 500 mVPP
   localparam logic [15:0] FS_CODE_DEFAULT = 16'hA000; // 800 mVPP
   localparam logic [15:0] FS_CODE_MAX = 16'hFFFF; // 1000 mVPP

   // ==========================================================
   // field positions
   localparam int POS_REFERENCE_SOURCE_BYPASS = 0;
   localparam int POS_STAMP_RECEIVER_ON = 0;
   localparam int POS_STAMP_LOWSWING_MODE = 1;
   localparam int POS_LANE_PREEMPH_LEVEL = 0;
   localparam int WID_LANE_PREEMPH_LEVEL = 3;
   localparam int POS_LANE_PREEMPH_EXTRA = 3;
   localparam int POS_DUAL_INPUT_SWAP = 4;
   localparam int POS_SINGLE_INPUT_SEL = 0;
   localparam int POS_STATUS_PENDING = 0;
   localparam int POS_STATUS_HELD = 1;
   localparam int POS_STATUS_APPLIED = 4;
   localparam int LANE_COUNT = 16;

   // ==========================================================
   // single-channel input selections
   typedef enum logic [1:0] {
      SINGLE_RESERVED = 2'h0,
      SINGLE_INPUT_A = 2'h1,
      SINGLE_INPUT_B = 2'h2,
      SINGLE_DUAL_INTERLEAVED = 2'h3
   } single_sel_t;

   // calibration gate states, gray along held -> running
   typedef enum logic {
      CAL_HELD = 1'b0,
      CAL_RUNNING = 1'b1
   } cal_state_t;

endpackage

// ### hdl/input_routing_apply.sv
// applies the input multiplexer selection when calibration is re-run
`timescale 1ns/1ps
`default_nettype none

module input_routing_apply (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] routingReg,
   input wire logic linkIsSingle,
   input wire logic calEnable,
   output logic convASampleB,
   output logic convBSampleB,
   output logic routingPending,
   output logic calHeld,
   output logic [7:0] appliedRouting
);

   // ==========================================================
   // state
   afe_cfg_pkg::cal_state_t state_q, state_d;
   logic [7:0] applied_q, applied_d;
   logic pending_q, pending_d;
   logic [7:0] lastSeen_q, lastSeen_d;
   logic aB_q, aB_d;
   logic bB_q, bB_d;

   // next state, applied routing and converter steering
   always_comb begin
      logic swap;
      afe_cfg_pkg::single_sel_t single;
      swap = applied_q[afe_cfg_pkg::POS_DUAL_INPUT_SWAP];
      single = afe_cfg_pkg::single_sel_t'(applied_q[afe_cfg_pkg::POS_SINGLE_INPUT_SEL +: 2]);
      state_d = state_q;
      applied_d = applied_q;
      pending_d = pending_q;
      lastSeen_d = routingReg;
      // a change in the selection waits for calibration
      if (routingReg != lastSeen_q) begin
         pending_d = 1'b1;
      end
      unique case (state_q)
         afe_cfg_pkg::CAL_HELD: begin
            if (calEnable) begin
               // calibration rising: new routing now takes effect
               state_d = afe_cfg_pkg::CAL_RUNNING;
               applied_d = routingReg;
               pending_d = 1'b0;
            end
         end
         afe_cfg_pkg::CAL_RUNNING: begin
            if (!calEnable) begin
               state_d = afe_cfg_pkg::CAL_HELD;
            end
         end
      endcase
      aB_d = aB_q;
      bB_d = bB_q;
      if (linkIsSingle) begin
         // swap bit ignored in single-channel modes
         unique case (single)
            afe_cfg_pkg::SINGLE_INPUT_A: begin
               aB_d = 1'b0;
               bB_d = 1'b0;
            end
            afe_cfg_pkg::SINGLE_INPUT_B: begin
               aB_d = 1'b1;
               bB_d = 1'b1;
            end
            afe_cfg_pkg::SINGLE_DUAL_INTERLEAVED: begin
               aB_d = 1'b0;
               bB_d = 1'b1;
            end
            afe_cfg_pkg::SINGLE_RESERVED: begin
               aB_d = aB_q; // reserved code keeps the last routing
               bB_d = bB_q;
            end
         endcase
      end else begin
         // single-input field ignored outside single-channel modes
         aB_d = swap;
         bB_d = !swap;
      end
   end

   // registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= afe_cfg_pkg::CAL_HELD;
         applied_q <= afe_cfg_pkg::RST_INPUT_ROUTING;
         pending_q <= 1'b0;
         lastSeen_q <= afe_cfg_pkg::RST_INPUT_ROUTING;
         aB_q <= 1'b0;
         bB_q <= 1'b1;
      end else begin
         state_q <= state_d;
         applied_q <= applied_d;
         pending_q <= pending_d;
         lastSeen_q <= lastSeen_d;
         aB_q <= aB_d;
         bB_q <= bB_d;
      end
   end

   assign convASampleB = aB_q;
   assign convBSampleB = bB_q;
   assign routingPending = pending_q;
   assign calHeld = (state_q == afe_cfg_pkg::CAL_HELD);
   assign appliedRouting = applied_q;

endmodule

`default_nettype wire

// ### test/afe_cfg_regs_props.sv
// port checker for the front end configuration register bank
`timescale 1ns/1ps
`default_nettype none

module afe_cfg_regs_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [15:0] regRdData,
   input wire logic linkIsSingle,
   input wire logic calEnable,
   input wire logic [15:0] inputAFullscaleCode,
   input wire logic [15:0] inputBFullscaleCode,
   input wire logic inputALowRange,
   input wire logic inputBLowRange,
   input wire logic referenceSourceBypass,
   input wire logic stampReceiverOn,
   input wire logic stampLowswingMode,
   input wire logic [47:0] lanePreemphLevel,
   input wire logic [15:0] lanePreemphExtra,
   input wire logic convASampleB,
   input wire logic convBSampleB,
   input wire logic routingPending
);
   // ==========================================
   // common clocking and access sequences
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence wrAt(logic [11:0] a);
      regWrite && regAddr == a;
   endsequence
   sequence calRise;
      !calEnable ##1 calEnable;
   endsequence

   // ==========================================
   // register bus and stored fields
   rd_data_a: assert property (
      regRead && regAddr == afe_cfg_pkg::OFF_INPUT_A_FULLSCALE
      |=> regRdData == $past(inputAFullscaleCode)) else $error("read data wrong");
   rd_idle_a: assert property (
      !regRead |=> regRdData == 16'h0000) else $error("read data not idle");
   wr_a_a: assert property (
      wrAt(afe_cfg_pkg::OFF_INPUT_A_FULLSCALE)
      |=> inputAFullscaleCode == $past(regWrData)) else $error("input a code");
   wr_b_a: assert property (
      wrAt(afe_cfg_pkg::OFF_INPUT_B_FULLSCALE)
      |=> inputBFullscaleCode == $past(regWrData)) else $error("input b code");
   low_range_a: assert property (
      {inputALowRange, inputBLowRange} == {inputAFullscaleCode < 16'h2000,
      inputBFullscaleCode < 16'h2000}) else $error("low range flag");
   lane_common_a: assert property (
      lanePreemphLevel == {16{lanePreemphLevel[2:0]}} &&
      lanePreemphExtra == {16{lanePreemphExtra[0]}}) else $error("lanes differ");
   stamp_wr_a: assert property (
      wrAt(afe_cfg_pkg::OFF_STAMP_INPUT_CONTROL) |=>
      {stampLowswingMode, stampReceiverOn} == $past(regWrData[1:0])) else $error("stamp");
   bypass_wr_a: assert property (
      wrAt(afe_cfg_pkg::OFF_REFERENCE_BYPASS)
      |=> referenceSourceBypass == $past(regWrData[0])) else $error("bypass bit");

   // ==========================================
   // routing only moves on calibration rise or on a change of linkIsSingle
   steer_hold_a: assert property (
      (!calEnable && $stable(linkIsSingle)) [*2]
      |=> $stable({convASampleB, convBSampleB})) else $error("steering moved");
   apply_clear_a: assert property (
      calRise |=> !routingPending) else $error("pending not cleared");
endmodule

`default_nettype wire

// ### test/test_analog_frontend_config_regs.sv
// self-checking bench for the front end configuration register bank
`timescale 1ns/1ps
`default_nettype none

module test_analog_frontend_config_regs;
   logic clk, rstn, regWrite, regRead, linkIsSingle, calEnable;
   logic aLow, bLow, bypass, stampOn, stampLow, convA, convB, pending;
   logic [11:0] regAddr;
   logic [15:0] regWrData, regRdData, aCode, bCode, lpExtra;
   logic [47:0] lpLevel;
   logic [1:0] lastConv;
   logic lastSingle;
   logic [3:0] v;
   int mismatches, nCompared;
   int cycles = 0;
   logic [11:0] addrs[6] = '{afe_cfg_pkg::OFF_INPUT_A_FULLSCALE,
      afe_cfg_pkg::OFF_INPUT_B_FULLSCALE, afe_cfg_pkg::OFF_REFERENCE_BYPASS,
      afe_cfg_pkg::OFF_STAMP_INPUT_CONTROL, afe_cfg_pkg::OFF_LANE_PREEMPHASIS,
      afe_cfg_pkg::OFF_INPUT_ROUTING};
   logic [15:0] rsts[6] = '{16'hA000, 16'hA000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
   logic [15:0] wv[6] = '{16'h1FFF, 16'hFFFF, 16'h12FF, 16'h12FF, 16'h12FF, 16'h12FF};

   // ==========================================
   // device under test
   analog_frontend_config_regs i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .linkIsSingle(linkIsSingle), .calEnable(calEnable),
      .inputAFullscaleCode(aCode), .inputBFullscaleCode(bCode), .inputALowRange(aLow),
      .inputBLowRange(bLow), .referenceSourceBypass(bypass), .stampReceiverOn(stampOn),
      .stampLowswingMode(stampLow), .lanePreemphLevel(lpLevel), .lanePreemphExtra(lpExtra),
      .convASampleB(convA), .convBSampleB(convB), .routingPending(pending));

   // 10 MHz clock
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // ==========================================
   // compare, bus and routing tasks
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      nCompared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'h1;
      @(posedge clk);
      regWrite <= 1'h0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'h1;
      @(posedge clk);
      regRead <= 1'h0;
      #1 chk(48'(regRdData), 48'(e));
   endtask

   // program routing with calibration held, then rerun calibration
   task automatic route(input logic s, input logic [7:0] r, input logic [1:0] e);
      @(posedge clk);
      calEnable <= 1'h0;
      linkIsSingle <= s;
      wr(afe_cfg_pkg::OFF_INPUT_ROUTING, {8'h00, r});
      repeat (2) @(posedge clk);
      #1 chk(48'(pending), 48'h1);
      if (s === lastSingle) chk(48'({convA, convB}), 48'(lastConv));
      @(posedge clk);
      calEnable <= 1'h1;
      repeat (2) @(posedge clk);
      #1 chk(48'({convA, convB}), 48'(e));
      chk(48'(pending), 48'h0);
      lastConv = e;
      lastSingle = s;
   endtask

   task automatic printVerdict();
      $display("compared %0d, mismatched %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         printVerdict();
      end
   end

   // ==========================================
   // main sequence
   initial begin
      rstn = 1'h0;
      regWrite = 1'h0;
      regRead = 1'h0;
      regAddr = 12'h000;
      regWrData = 16'h0000;
      linkIsSingle = 1'h0;
      calEnable = 1'h1;
      mismatches = 0;
      nCompared = 0;
      lastConv = 2'h1;
      lastSingle = 1'h0;
      repeat (3) @(posedge clk);
      #1 chk({aCode, bCode, 12'h000, convA, convB, pending, aLow}, 48'hA000A0000004);
      chk({lpLevel[15:0], lpExtra, 13'h0000, bypass, stampOn, stampLow}, 48'h0);
      rstn <= 1'h1;
      foreach (addrs[i]) rd(addrs[i], rsts[i]);
      rd(afe_cfg_pkg::OFF_ROUTING_STATUS, 16'h0100);
      foreach (addrs[i]) begin
         wr(addrs[i], wv[i]);
         rd(addrs[i], (i < 2) ? wv[i] : {8'h00, wv[i][7:0]});
      end
      chk(48'({aLow, bLow}), 48'h2);
      wr(afe_cfg_pkg::OFF_INPUT_A_FULLSCALE, afe_cfg_pkg::FS_CODE_MIN_RECOMMENDED);
      #1 chk(48'({aLow, aCode}), 48'h2000);
      wr(afe_cfg_pkg::OFF_INPUT_B_FULLSCALE, 16'h1FFF);
      #1 chk(48'({aLow, bLow, bCode}), 48'h11FFF);
      wr(12'h031, 16'h1234);
      rd(12'h031, 16'h0000);
      rd(afe_cfg_pkg::OFF_INPUT_A_FULLSCALE, 16'h2000);
      @(posedge clk);
      #1 chk(48'(regRdData), 48'h0);
      for (int i = 0; i < 16; i++) begin
         v = i[3:0];
         wr(afe_cfg_pkg::OFF_STAMP_INPUT_CONTROL, {12'h000, v});
         wr(afe_cfg_pkg::OFF_LANE_PREEMPHASIS, {12'h000, v});
         wr(afe_cfg_pkg::OFF_REFERENCE_BYPASS, {12'h000, v});
         #1 chk(48'({stampLow, stampOn}), 48'(v[1:0]));
         chk(48'(bypass), 48'(v[0]));
         chk(lpLevel, {16{v[2:0]}});
         chk(48'(lpExtra), 48'({16{v[3]}}));
      end
      route(1'h0, 8'h10, 2'h2);
      route(1'h0, 8'h02, 2'h1);
      route(1'h1, 8'h01, 2'h0);
      route(1'h1, 8'h02, 2'h3);
      route(1'h1, 8'h03, 2'h1);
      route(1'h1, 8'h12, 2'h3);
      route(1'h1, 8'h00, 2'h3);
      printVerdict();
   end
endmodule

bind analog_frontend_config_regs afe_cfg_regs_props i_props (.clk(clk), .rstn(rstn),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .linkIsSingle(linkIsSingle), .calEnable(calEnable),
   .inputAFullscaleCode(inputAFullscaleCode), .inputBFullscaleCode(inputBFullscaleCode),
   .inputALowRange(inputALowRange), .inputBLowRange(inputBLowRange),
   .referenceSourceBypass(referenceSourceBypass), .stampReceiverOn(stampReceiverOn),
   .stampLowswingMode(stampLowswingMode), .lanePreemphLevel(lanePreemphLevel),
   .lanePreemphExtra(lanePreemphExtra), .convASampleB(convASampleB),
   .convBSampleB(convBSampleB), .routingPending(routingPending));

`default_nettype wire
